//--- psc_pkg.sv
// Purpose: Shared constants for the protection switch control block
// Assumes: Register map reached over the serial slave port only
// Notes: Offsets are register indices on the serial port
package psc_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam logic [6:0] SLAVE_ADDR = 7'h28;
    localparam int unsigned NUM_IN = 6;
    // Input vector positions
    localparam int unsigned IN_SUPPLY = 0;
    localparam int unsigned IN_LOCKOUT = 1;
    localparam int unsigned IN_OV_CC = 2;
    localparam int unsigned IN_OV_SBU = 3;
    localparam int unsigned IN_MOIST = 4;
    localparam int unsigned IN_FTP_LOW = 5;
    // Register offsets
    localparam logic [7:0] REG_SWITCH_CTRL = 8'h01;
    localparam logic [7:0] REG_CONTROL = 8'h02;
    localparam logic [7:0] REG_IRQ_MASK = 8'h03;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h05;
    localparam logic [7:0] REG_DEVICE_RESET_CONTROL = 8'h0B;
    // Field positions
    localparam int unsigned SW_CC = 0;
    localparam int unsigned SW_SBU = 1;
    localparam int unsigned SW_FTP_SBU2 = 2;
    localparam int unsigned CTL_MANUAL = 0;
    localparam int unsigned RST_DEVICE = 0;
    localparam int unsigned IRQ_OV_CC = 0;
    localparam int unsigned IRQ_OV_SBU = 1;
    localparam int unsigned IRQ_REC_CC = 2;
    localparam int unsigned IRQ_REC_SBU = 3;
    // Reset values and last bit index
    localparam logic [7:0] SWITCH_CTRL_RST = 8'h03;
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam logic [2:0] LAST_BIT = 3'h7;
    typedef enum logic [2:0] {
        PSC_IDLE = 3'b000,
        PSC_ADDR = 3'b001,
        PSC_REG = 3'b010,
        PSC_WR = 3'b011,
        PSC_ACK = 3'b100,
        PSC_RD = 3'b101,
        PSC_MACK = 3'b110,
        PSC_RDW = 3'b111
    } psc_i2c_t;
endpackage : psc_pkg

//--- psc_protection_switch_control.sv
// Purpose: Switch control, fault handling, interrupt and serial slave port
// Assumes: Analog front end gives synchronous-free level indications
// Notes: Serial engine samples SCL/SDA on its own link clock
//
// Overview of operation
// - After reset with good supply, close CC switches automatically; SBU closes only with factory pin low.
// - Without valid supply, keep Rd terminations on both CC lines.
// - On supply return, drop Rd and close both CC switches.
// - On supply lockout, open CC and SBU switches and reapply Rd.
// - Device reset bit restores defaults; switches open briefly then close.
// - CC over-voltage opens both CC paths, SBU stays closed.
// - SBU over-voltage opens only the SBU path.
// - Over-voltage updates interrupt status and pulls interrupt line low.
// - Fault clearing recloses path by itself and raises recovery interrupt.
// - Unpulled factory pin routes to SBU1, software may pick SBU2.
// - Factory pin held low closes the normal SBU pass switches.
// - Manual mode makes software switch settings override automatic control.
// - Moisture sequence or over-voltage forces switches open despite manual.
// - Any interrupt status bit set pulls the interrupt line low.
// - Interrupt line stays low until host reads interrupt status.
// - Masks reset clear; set mask stops its status bit from setting.
// - Interrupt line works right after reset with no setup.
// - Acts as fast-mode serial slave; host SCL at most 400 kHz.
// - Answers at fixed seven-bit address 0101000, low bit selects read.
`timescale 1ns/1ps
module psc_protection_switch_control
    import psc_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic LINK_CLK,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    output logic IRQ_OUT_N_OUT,
    output logic IRQ_OUT_N_OE,
    input wire logic SUPPLY_VALID,
    input wire logic SUPPLY_LOW_LOCKOUT,
    input wire logic OVERVOLTAGE_PROTECT_CC,
    input wire logic OVERVOLTAGE_PROTECT_SBU,
    input wire logic MOISTURE_BUSY,
    input wire logic FACTORY_TEST_PIN_LOW,
    output logic CC_SWITCH_CLOSED,
    output logic SBU_SWITCH_CLOSED,
    output logic RD_APPLIED,
    output logic FACTORY_TEST_PIN_TO_SBU1,
    output logic FACTORY_TEST_PIN_TO_SBU2
);
    // ==========================================================
    // Input synchronisers, main clock
    logic [NUM_IN-1:0] in_raw;
    logic [NUM_IN-1:0] in_s1_q;
    logic [NUM_IN-1:0] in_s2_q;
    logic [NUM_IN-1:0] in_prev_q;
    assign in_raw = {FACTORY_TEST_PIN_LOW, MOISTURE_BUSY, OVERVOLTAGE_PROTECT_SBU,
                     OVERVOLTAGE_PROTECT_CC, SUPPLY_LOW_LOCKOUT, SUPPLY_VALID};
    always_ff @(posedge CLK) begin
        in_s1_q <= in_raw;
        in_s2_q <= in_s1_q;
        in_prev_q <= in_s2_q;
    end
    logic supply_ok;
    logic ov_cc_s;
    logic ov_sbu_s;
    logic moist_s;
    logic ftp_low_s;
    assign supply_ok = in_s2_q[IN_SUPPLY] & ~in_s2_q[IN_LOCKOUT];
    assign ov_cc_s = in_s2_q[IN_OV_CC];
    assign ov_sbu_s = in_s2_q[IN_OV_SBU];
    assign moist_s = in_s2_q[IN_MOIST];
    assign ftp_low_s = in_s2_q[IN_FTP_LOW];

    // ==========================================================
    // Link domain reset and pin synchronisers
    logic lrst_s1_q;
    logic lrst_q;
    logic scl_s1_q;
    logic scl_s2_q;
    logic scl_prev_q;
    logic sda_s1_q;
    logic sda_s2_q;
    logic sda_prev_q;
    always_ff @(posedge LINK_CLK) begin
        lrst_s1_q <= RESET;
        lrst_q <= lrst_s1_q;
        scl_s1_q <= SCL_IN;
        scl_s2_q <= scl_s1_q;
        scl_prev_q <= scl_s2_q;
        sda_s1_q <= SDA_IN;
        sda_s2_q <= sda_s1_q;
        sda_prev_q <= sda_s2_q;
    end
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    assign scl_rise = scl_s2_q & ~scl_prev_q;
    assign scl_fall = ~scl_s2_q & scl_prev_q;
    assign bus_start = scl_s2_q & scl_prev_q & sda_prev_q & ~sda_s2_q;
    assign bus_stop = scl_s2_q & scl_prev_q & ~sda_prev_q & sda_s2_q;

    // ==========================================================
    // Serial slave engine, link clock
    // Read data must land within one SCL high phase; the handshake is far faster
    psc_i2c_t st_q;
    psc_i2c_t nxt_q;
    logic [2:0] cnt_q;
    logic [7:0] sr_q;
    logic [7:0] ptr_q;
    logic sda_oe_q;
    logic req_tgl_q;
    logic req_we_q;
    logic [7:0] req_addr_q;
    logic [7:0] req_wdata_q;
    logic ack_s1_q;
    logic ack_s2_q;
    logic ack_prev_q;
    logic [7:0] rd_l_q;
    logic ack_tgl_q;
    logic [7:0] rd_data_q;
    logic [7:0] byte_in;
    assign byte_in = {sr_q[6:0], sda_s2_q};

    always_ff @(posedge LINK_CLK) begin
        ack_s1_q <= ack_tgl_q;
        ack_s2_q <= ack_s1_q;
        ack_prev_q <= ack_s2_q;
        if (lrst_q) begin
            rd_l_q <= ZERO8;
        end else if (ack_s2_q != ack_prev_q) begin
            rd_l_q <= rd_data_q;
        end
    end

    always_ff @(posedge LINK_CLK) begin
        if (lrst_q) begin
            st_q <= PSC_IDLE;
            nxt_q <= PSC_IDLE;
            cnt_q <= 3'h0;
            sr_q <= ZERO8;
            ptr_q <= ZERO8;
            sda_oe_q <= 1'b0;
            req_tgl_q <= 1'b0;
            req_we_q <= 1'b0;
            req_addr_q <= ZERO8;
            req_wdata_q <= ZERO8;
        end else if (bus_start) begin
            st_q <= PSC_ADDR;
            cnt_q <= 3'h0;
            sda_oe_q <= 1'b0;
        end else if (bus_stop) begin
            st_q <= PSC_IDLE;
            sda_oe_q <= 1'b0;
        end else if (scl_rise) begin
            case (st_q)
                PSC_ADDR, PSC_REG, PSC_WR: begin
                    sr_q <= byte_in;
                    cnt_q <= cnt_q + 3'h1;
                    if (cnt_q == LAST_BIT) begin
                        st_q <= PSC_ACK;
                        if (st_q == PSC_ADDR) begin
                            if (byte_in[7:1] != SLAVE_ADDR) begin
                                st_q <= PSC_IDLE;
                            end else if (byte_in[0]) begin
                                nxt_q <= PSC_RD;
                                req_we_q <= 1'b0;
                                req_addr_q <= ptr_q;
                                ptr_q <= ptr_q + 8'h01;
                                req_tgl_q <= ~req_tgl_q;
                            end else begin
                                nxt_q <= PSC_REG;
                            end
                        end else if (st_q == PSC_REG) begin
                            ptr_q <= byte_in;
                            nxt_q <= PSC_WR;
                        end else begin
                            req_we_q <= 1'b1;
                            req_addr_q <= ptr_q;
                            req_wdata_q <= byte_in;
                            ptr_q <= ptr_q + 8'h01;
                            req_tgl_q <= ~req_tgl_q;
                            nxt_q <= PSC_WR;
                        end
                    end
                end
                PSC_RD: begin
                    cnt_q <= cnt_q + 3'h1;
                    if (cnt_q == LAST_BIT) begin
                        st_q <= PSC_MACK;
                    end
                end
                PSC_MACK: begin
                    if (!sda_s2_q) begin
                        st_q <= PSC_RDW;
                        req_we_q <= 1'b0;
                        req_addr_q <= ptr_q;
                        ptr_q <= ptr_q + 8'h01;
                        req_tgl_q <= ~req_tgl_q;
                    end else begin
                        st_q <= PSC_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (st_q)
                PSC_ACK: begin
                    if (!sda_oe_q) begin
                        sda_oe_q <= 1'b1;
                    end else begin
                        st_q <= nxt_q;
                        cnt_q <= 3'h0;
                        sda_oe_q <= 1'b0;
                        if (nxt_q == PSC_RD) begin
                            sr_q <= rd_l_q;
                            sda_oe_q <= ~rd_l_q[7];
                        end
                    end
                end
                PSC_RD: begin
                    sr_q <= {sr_q[6:0], 1'b0};
                    sda_oe_q <= ~sr_q[6];
                end
                PSC_RDW: begin
                    st_q <= PSC_RD;
                    cnt_q <= 3'h0;
                    sr_q <= rd_l_q;
                    sda_oe_q <= ~rd_l_q[7];
                end
                default: begin
                    sda_oe_q <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // Request crossing into the main clock
    logic req_s1_q;
    logic req_s2_q;
    logic req_prev_q;
    logic req_new;
    always_ff @(posedge CLK) begin
        req_s1_q <= req_tgl_q;
        req_s2_q <= req_s1_q;
        req_prev_q <= req_s2_q;
    end
    assign req_new = req_s2_q != req_prev_q;

    // ==========================================================
    // Register file
    logic [7:0] sw_ctl_q;
    logic [7:0] ctl_q;
    logic [7:0] irq_mask_q;
    logic [7:0] irq_status_q;
    logic soft_rst_q;
    logic cc_closed_q;
    logic sbu_closed_q;
    logic rd_q;
    logic ftp1_q;
    logic ftp2_q;
    logic wr_hit;
    logic rd_hit;
    logic [7:0] irq_set;
    logic [7:0] irq_clr;
    assign wr_hit = req_new & req_we_q;
    assign rd_hit = req_new & ~req_we_q;

    function automatic logic [7:0] reg_read(input logic [7:0] a);
        case (a)
            REG_SWITCH_CTRL: reg_read = sw_ctl_q;
            REG_CONTROL: reg_read = ctl_q;
            REG_IRQ_MASK: reg_read = irq_mask_q;
            REG_IRQ_STATUS: reg_read = irq_status_q;
            REG_STATUS: reg_read = {3'h0, ov_sbu_s, ov_cc_s, rd_q, sbu_closed_q, cc_closed_q};
            default: reg_read = ZERO8;
        endcase
    endfunction : reg_read

    always_ff @(posedge CLK) begin
        if (RESET) begin
            ack_tgl_q <= 1'b0;
            rd_data_q <= ZERO8;
        end else if (req_new) begin
            ack_tgl_q <= ~ack_tgl_q;
            rd_data_q <= reg_read(req_addr_q);
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET || soft_rst_q) begin
            sw_ctl_q <= SWITCH_CTRL_RST;
            ctl_q <= ZERO8;
            irq_mask_q <= ZERO8;
            soft_rst_q <= 1'b0;
        end else begin
            if (wr_hit && req_addr_q == REG_SWITCH_CTRL) begin
                sw_ctl_q <= req_wdata_q;
            end
            if (wr_hit && req_addr_q == REG_CONTROL) begin
                ctl_q <= req_wdata_q;
            end
            if (wr_hit && req_addr_q == REG_IRQ_MASK) begin
                irq_mask_q <= req_wdata_q;
            end
            soft_rst_q <= wr_hit && req_addr_q == REG_DEVICE_RESET_CONTROL
                          && req_wdata_q[RST_DEVICE];
        end
    end

    // ==========================================================
    // Interrupt status
    // Set wins over the read clear so an event in the read cycle survives
    always_comb begin
        irq_set = ZERO8;
        irq_set[IRQ_OV_CC] = ov_cc_s & ~in_prev_q[IN_OV_CC];
        irq_set[IRQ_OV_SBU] = ov_sbu_s & ~in_prev_q[IN_OV_SBU];
        irq_set[IRQ_REC_CC] = ~ov_cc_s & in_prev_q[IN_OV_CC];
        irq_set[IRQ_REC_SBU] = ~ov_sbu_s & in_prev_q[IN_OV_SBU];
        irq_set = irq_set & ~irq_mask_q;
        irq_clr = (rd_hit && req_addr_q == REG_IRQ_STATUS) ? irq_status_q : ZERO8;
    end

    logic irq_low_q;
    always_ff @(posedge CLK) begin
        if (RESET || soft_rst_q) begin
            irq_status_q <= ZERO8;
            irq_low_q <= 1'b0;
        end else begin
            irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
            irq_low_q <= |irq_status_q;
        end
    end

    // ==========================================================
    // Switch control
    logic manual;
    logic cc_want;
    logic sbu_want;
    assign manual = ctl_q[CTL_MANUAL];
    assign cc_want = manual ? sw_ctl_q[SW_CC] : 1'b1;
    assign sbu_want = manual ? sw_ctl_q[SW_SBU] : ftp_low_s;

    always_ff @(posedge CLK) begin
        if (RESET || soft_rst_q) begin
            cc_closed_q <= 1'b0;
            sbu_closed_q <= 1'b0;
            rd_q <= 1'b1;
            ftp1_q <= 1'b0;
            ftp2_q <= 1'b0;
        end else begin
            cc_closed_q <= supply_ok & cc_want & ~ov_cc_s & ~moist_s;
            sbu_closed_q <= supply_ok & sbu_want & ~ov_sbu_s & ~moist_s;
            rd_q <= ~supply_ok;
            ftp1_q <= supply_ok & ~ftp_low_s & ~sw_ctl_q[SW_FTP_SBU2] & ~ov_sbu_s;
            ftp2_q <= supply_ok & ~ftp_low_s & sw_ctl_q[SW_FTP_SBU2] & ~ov_sbu_s;
        end
    end

    // ==========================================================
    // Pin drivers; open-drain lines only ever pull low
    logic sda_out_q;
    logic irq_out_q;
    always_ff @(posedge CLK) begin
        sda_out_q <= 1'b0;
        irq_out_q <= 1'b0;
    end
    assign SDA_OUT = sda_out_q;
    assign SDA_OE = sda_oe_q;
    assign IRQ_OUT_N_OUT = irq_out_q;
    assign IRQ_OUT_N_OE = irq_low_q;
    assign CC_SWITCH_CLOSED = cc_closed_q;
    assign SBU_SWITCH_CLOSED = sbu_closed_q;
    assign RD_APPLIED = rd_q;
    assign FACTORY_TEST_PIN_TO_SBU1 = ftp1_q;
    assign FACTORY_TEST_PIN_TO_SBU2 = ftp2_q;

    // ==========================================================
    // Checks
    a_auto_close: assert property (@(posedge CLK) disable iff (RESET)
        supply_ok && !ov_cc_s && !moist_s && !manual && !soft_rst_q |=> cc_closed_q)
        else $error("CC switch not closed automatically");
    a_rd_no_supply: assert property (@(posedge CLK) disable iff (RESET)
        !supply_ok && !soft_rst_q |=> rd_q && !cc_closed_q && !sbu_closed_q)
        else $error("Rd missing or switch closed without supply");
    a_supply_back: assert property (@(posedge CLK) disable iff (RESET)
        $rose(supply_ok) && !ov_cc_s && !moist_s && !manual && !soft_rst_q
        |=> !rd_q && cc_closed_q) else $error("Supply return did not restore CC");
    a_soft_reset: assert property (@(posedge CLK) disable iff (RESET)
        soft_rst_q |=> !cc_closed_q && !sbu_closed_q && ctl_q == ZERO8)
        else $error("Device reset did not restore defaults");
    a_cc_ov_open: assert property (@(posedge CLK) disable iff (RESET)
        ov_cc_s && !ov_sbu_s && supply_ok && !moist_s && sbu_want && !soft_rst_q
        |=> !cc_closed_q && sbu_closed_q) else $error("CC fault path wrong");
    a_sbu_ov_open: assert property (@(posedge CLK) disable iff (RESET)
        ov_sbu_s |=> !sbu_closed_q && !ftp1_q && !ftp2_q)
        else $error("SBU fault did not open SBU");
    a_irq_follows: assert property (@(posedge CLK) disable iff (RESET)
        irq_set != ZERO8 && !soft_rst_q |=> irq_status_q != ZERO8 ##1 IRQ_OUT_N_OE)
        else $error("Event did not pull interrupt low");
    a_recover_flag: assert property (@(posedge CLK) disable iff (RESET)
        $fell(ov_cc_s) && !irq_mask_q[IRQ_REC_CC] && !soft_rst_q |=> irq_status_q[IRQ_REC_CC])
        else $error("Recovery not flagged");
    a_mask_block: assert property (@(posedge CLK) disable iff (RESET)
        (irq_status_q & ~$past(irq_status_q) & $past(irq_mask_q)) == ZERO8)
        else $error("Masked status bit set");
    a_manual_open: assert property (@(posedge CLK) disable iff (RESET)
        manual && !sw_ctl_q[SW_CC] |=> !cc_closed_q)
        else $error("Manual open ignored");
    a_moist_open: assert property (@(posedge CLK) disable iff (RESET)
        moist_s |=> !cc_closed_q && !sbu_closed_q) else $error("Moisture did not open switches");
endmodule : psc_protection_switch_control

//--- psc_host_model.sv
// Purpose: Serial host model for register access to the switch control block
// Assumes: Bench resolves SDA with a pull-up and feeds the level back here
// Notes: 125 clk per bit, so SCL never runs above 400 kHz at 50 MHz
`timescale 1ns/1ps
module psc_host_model
    import psc_pkg::*;
(
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    // ==========
    // Bus idle
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // ==========
    // Bit and frame timing
    task w(input int n);
        repeat (n) @(posedge clk);
    endtask : w
    // Low 1.5 us, high 1 us, period 2.5 us
    task bit_io(input logic b, output logic r);
        w(30);
        sda_low <= !b;
        w(45);
        scl <= 1'b1;
        w(25);
        r = sda;
        w(25);
        scl <= 1'b0;
    endtask : bit_io
    // Start a=0 b=1, stop a=1 b=0; sda_low goes to a while SCL low, then to b while SCL high
    task cond(input logic a, input logic b);
        w(30);
        sda_low <= a;
        w(30);
        scl <= 1'b1;
        w(40);
        sda_low <= b;
        w(40);
        scl <= a;
    endtask : cond
    // Byte MSB first, then the acknowledge bit with SDA released
    task tx(input logic [7:0] v, output logic [7:0] q, inout logic ok);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(v[i], q[i]);
        end
        bit_io(1'b1, r);
        ok = ok & !r;
    endtask : tx
    // ==========
    // Register cycles
    task wr(input logic [6:0] a, input logic [7:0] off, input logic [7:0] v, output logic ok);
        logic [7:0] q;
        ok = 1'b1;
        cond(1'b0, 1'b1);
        tx({a, 1'b0}, q, ok);
        tx(off, q, ok);
        tx(v, q, ok);
        cond(1'b1, 1'b0);
    endtask : wr
    // Pointer write, repeated start, one byte ended by NACK
    task rd(input logic [7:0] off, output logic [7:0] v, output logic ok);
        logic nack;
        logic [7:0] q;
        ok = 1'b1;
        nack = 1'b1;
        cond(1'b0, 1'b1);
        tx({SLAVE_ADDR, 1'b0}, q, ok);
        tx(off, q, ok);
        cond(1'b0, 1'b1);
        tx({SLAVE_ADDR, 1'b1}, q, ok);
        tx(8'hFF, v, nack);
        cond(1'b1, 1'b0);
    endtask : rd
endmodule : psc_host_model

//--- psc_protection_switch_control_test.sv
// Purpose: Self-checking bench for the protection switch control block
// Assumes: Pull-ups on SDA and on the interrupt line
// Notes: Traffic comes from the host model; pin levels change on CLK edges
`timescale 1ns/1ps
module psc_protection_switch_control_test
    import psc_pkg::*;
();
    logic clk = 1'b0, lclk = 1'b0, rst = 1'b1, arm = 1'b0, saw_open = 1'b0;
    logic supply = 1'b0, lockout = 1'b0, ov_cc = 1'b0, ov_sbu = 1'b0;
    logic moist = 1'b0, ftp_low = 1'b0, ok;
    logic scl, sda_low, sda_oe, irq_oe, cc, sbu, rd_on, to1, to2, sda_o, irq_o;
    logic [7:0] d;
    int err_total = 0, checks = 0;
    wire sda = !(sda_low | sda_oe);
    wire irq_n = !irq_oe;
    // ==========
    // Clocks, link clock unrelated in phase
    always #10 clk = ~clk;
    initial begin
        #2.7;
        forever #6 lclk = ~lclk;
    end
    psc_protection_switch_control dut (
        .CLK(clk), .RESET(rst), .LINK_CLK(lclk), .SCL_IN(scl), .SDA_IN(sda),
        .SDA_OUT(sda_o), .SDA_OE(sda_oe), .IRQ_OUT_N_OUT(irq_o), .IRQ_OUT_N_OE(irq_oe),
        .SUPPLY_VALID(supply), .SUPPLY_LOW_LOCKOUT(lockout),
        .OVERVOLTAGE_PROTECT_CC(ov_cc), .OVERVOLTAGE_PROTECT_SBU(ov_sbu),
        .MOISTURE_BUSY(moist), .FACTORY_TEST_PIN_LOW(ftp_low),
        .CC_SWITCH_CLOSED(cc), .SBU_SWITCH_CLOSED(sbu), .RD_APPLIED(rd_on),
        .FACTORY_TEST_PIN_TO_SBU1(to1), .FACTORY_TEST_PIN_TO_SBU2(to2)
    );
    psc_host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
    // Device reset opens the switches for one cycle only, so catch it here
    always @(posedge clk) begin
        if (arm && !cc) begin
            saw_open <= 1'b1;
        end
    end
    // ==========
    // Checking and access tasks
    task check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task results();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results
    task wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt
    // Bits: cc, sbu, rd, interrupt level, route sbu1, route sbu2
    task st(input logic [5:0] e);
        wt(6);
        check({2'h0, cc, sbu, rd_on, irq_n, to1, to2}, {2'h0, e});
    endtask : st
    task wrc(input logic [7:0] off, input logic [7:0] v);
        host.wr(SLAVE_ADDR, off, v, ok);
        check({7'h00, ok}, 8'h01);
    endtask : wrc
    task rdc(input logic [7:0] off, input logic [7:0] e);
        host.rd(off, d, ok);
        check({7'h00, ok}, 8'h01);
        check(d, e);
    endtask : rdc
    // ==========
    // Scenarios
    initial begin
        wt(20);
        rst <= 1'b0;
        wt(6);
        check({5'h00, cc, rd_on, irq_n}, 8'h03);
        check({6'h00, sda_o, irq_o}, ZERO8);
        supply <= 1'b1;
        st(6'b100110);
        rdc(REG_IRQ_MASK, ZERO8);
        wrc(REG_SWITCH_CTRL, 8'h07);
        st(6'b100101);
        ftp_low <= 1'b1;
        st(6'b110100);
        rdc(REG_STATUS, 8'h03);
        ov_cc <= 1'b1;
        st(6'b010000);
        rdc(REG_STATUS, 8'h0A);
        ov_cc <= 1'b0;
        st(6'b110000);
        rdc(REG_IRQ_STATUS, 8'h05);
        st(6'b110100);
        rdc(REG_IRQ_STATUS, ZERO8);
        ov_sbu <= 1'b1;
        st(6'b100000);
        ov_sbu <= 1'b0;
        st(6'b110000);
        rdc(REG_IRQ_STATUS, 8'h0A);
        wrc(REG_IRQ_MASK, 8'h05);
        ov_cc <= 1'b1;
        st(6'b010100);
        ov_cc <= 1'b0;
        st(6'b110100);
        rdc(REG_IRQ_STATUS, ZERO8);
        wrc(REG_SWITCH_CTRL, ZERO8);
        wrc(REG_CONTROL, 8'h01);
        st(6'b000100);
        wrc(REG_SWITCH_CTRL, SWITCH_CTRL_RST);
        st(6'b110100);
        host.wr(7'h29, REG_SWITCH_CTRL, ZERO8, ok);
        check({7'h00, ok}, ZERO8);
        st(6'b110100);
        moist <= 1'b1;
        st(6'b000100);
        moist <= 1'b0;
        ov_sbu <= 1'b1;
        st(6'b100000);
        ov_sbu <= 1'b0;
        st(6'b110000);
        arm <= 1'b1;
        wrc(REG_DEVICE_RESET_CONTROL, 8'h01);
        arm <= 1'b0;
        check({7'h00, saw_open}, 8'h01);
        st(6'b110100);
        rdc(REG_CONTROL, ZERO8);
        rdc(REG_SWITCH_CTRL, SWITCH_CTRL_RST);
        rdc(REG_DEVICE_RESET_CONTROL, ZERO8);
        rdc(8'h0F, ZERO8);
        lockout <= 1'b1;
        st(6'b001100);
        results();
    end
    // About 1.6 ms of serial traffic expected, so 2 ms means a hang
    initial begin
        #2_000_000;
        err_total++;
        results();
    end
endmodule : psc_protection_switch_control_test
